// *** verilog/rpcc_ctrl.sv ***
// radio power-up timeout and synthesizer calibration control
`timescale 1ns/1ps
`default_nettype none
`include "rpcc_defs.svh"

module rpcc_ctrl
(
  // clock, reset and clock enable
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // register port
  input  wire logic              cfg_wr_en,
  input  wire logic [5:0]        cfg_addr,
  input  wire logic [7:0]        cfg_wdata,
  output logic      [7:0]        cfg_rdata,
  // radio state events
  input  wire rpcc_pkg::rpcc_evt_t radio_evt,
  // oscillator and sleep status
  input  wire logic              osc_settled,
  input  wire logic              sleep_active,
  // outputs
  output logic                   synth_cal_start,
  output logic                   crystal_osc_enable,
  output logic                   chip_ready_low,
  output logic                   osc_stable_flag
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    rpcc_pkg::rpcc_cfg_t cfg;        // timing config register
    logic [7:0]          rdata;      // read data
    logic [1:0]          return_cnt; // automatic returns seen in every-fourth mode
    logic                cal;        // calibration start pulse
    logic                osc_en;     // oscillator enable
    logic                ready_n;    // chip ready, active low
    logic                stable;     // oscillator stable flag
  } rpcc_state_t;

  rpcc_state_t st_ff;     // registered state
  rpcc_state_t nxt_st;    // next state
  logic        tmr_done;  // power-up timeout reached
  logic        cfg_hit;   // register address match

  assign cfg_hit = (cfg_addr == `RPCC_TIMING_CFG_ADDR);

  // ---------------------------------------------------------------
  // power-up timer
  // ---------------------------------------------------------------
  // timer runs on core_clk with the same clock enable as this block
  rpcc_powerup_timer u_timer
  (
    .core_clk      (core_clk),
    .reset         (reset),
    .clk_en        (clk_en),
    .osc_settled   (osc_settled),
    .expiry_select (st_ff.cfg.powerup_expiry_select),
    .timeout_done  (tmr_done)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.cal = 1'b0;

    // register write, unused bits forced to zero
    if (cfg_wr_en && cfg_hit)
      nxt_st.cfg = rpcc_pkg::rpcc_cfg_t'(cfg_wdata & `RPCC_CFG_USED_MASK);

    // read data follows the address one cycle later
    nxt_st.rdata = cfg_hit ? 8'(st_ff.cfg) : 8'h00;

    // manual strobe works in every mode
    if (radio_evt.synth_cal_strobe)
      nxt_st.cal = 1'b1;

    unique case (st_ff.cfg.synth_autocal_select)
      rpcc_pkg::RPCC_CAL_NEVER:
      begin
        // no automatic calibration
      end
      rpcc_pkg::RPCC_CAL_ON_START:
      begin
        if (radio_evt.idle_to_active)
          nxt_st.cal = 1'b1;
      end
      rpcc_pkg::RPCC_CAL_ON_RETURN:
      begin
        if (radio_evt.auto_return_idle)
          nxt_st.cal = 1'b1;
      end
      rpcc_pkg::RPCC_CAL_EVERY_4TH:
      begin
        if (radio_evt.auto_return_idle)
        begin
          nxt_st.return_cnt = st_ff.return_cnt + 2'h1;
          if (st_ff.return_cnt == `RPCC_RETURN_LAST)
            nxt_st.cal = 1'b1;
        end
      end
    endcase

    // oscillator off in sleep unless kept on
    nxt_st.osc_en = !sleep_active || st_ff.cfg.osc_keep_on_in_sleep;

    nxt_st.ready_n = !tmr_done;
    nxt_st.stable  = tmr_done;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_ff            <= '0;
      st_ff.cfg        <= rpcc_pkg::rpcc_cfg_t'(`RPCC_TIMING_CFG_RESET);
      st_ff.osc_en     <= 1'b1;
      st_ff.ready_n    <= 1'b1;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign cfg_rdata          = st_ff.rdata;
  assign synth_cal_start    = st_ff.cal;
  assign crystal_osc_enable = st_ff.osc_en;
  assign chip_ready_low     = st_ff.ready_n;
  assign osc_stable_flag    = st_ff.stable;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_cal_never_auto: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && st_ff.cfg.synth_autocal_select == rpcc_pkg::RPCC_CAL_NEVER
    && !radio_evt.synth_cal_strobe |=> !synth_cal_start)
    else $error("automatic calibration in never mode");

  a_cal_strobe: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && radio_evt.synth_cal_strobe |=> synth_cal_start)
    else $error("manual strobe did not calibrate");

  a_cal_on_start: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && st_ff.cfg.synth_autocal_select == rpcc_pkg::RPCC_CAL_ON_START
    && radio_evt.idle_to_active |=> synth_cal_start)
    else $error("no calibration on leaving idle");

  a_cal_on_return: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && st_ff.cfg.synth_autocal_select == rpcc_pkg::RPCC_CAL_ON_RETURN
    && radio_evt.auto_return_idle |=> synth_cal_start)
    else $error("no calibration on return to idle");

  a_cal_fourth: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && st_ff.cfg.synth_autocal_select == rpcc_pkg::RPCC_CAL_EVERY_4TH
    && radio_evt.auto_return_idle && !radio_evt.synth_cal_strobe
    |=> synth_cal_start == ($past(st_ff.return_cnt) == `RPCC_RETURN_LAST))
    else $error("every-fourth calibration wrong");

  a_osc_keep_on: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && (!sleep_active || st_ff.cfg.osc_keep_on_in_sleep)
    |=> crystal_osc_enable)
    else $error("oscillator stopped while required");

  a_osc_sleep_off: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && sleep_active && !st_ff.cfg.osc_keep_on_in_sleep
    |=> !crystal_osc_enable)
    else $error("oscillator left on in sleep");

  a_ready_pair: assert property (@(posedge core_clk) disable iff (reset)
    chip_ready_low != osc_stable_flag)
    else $error("ready and stable flag out of step");

  a_ready_drop: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !osc_settled) ##1 clk_en |=> chip_ready_low)
    else $error("chip ready without settled oscillator");

  c_fourth_cal: cover property (@(posedge core_clk) disable iff (reset)
    st_ff.cfg.synth_autocal_select == rpcc_pkg::RPCC_CAL_EVERY_4TH && synth_cal_start);

  c_ready_fall: cover property (@(posedge core_clk) disable iff (reset)
    $fell(chip_ready_low));

  c_cfg_write: cover property (@(posedge core_clk) disable iff (reset)
    clk_en && cfg_wr_en && cfg_hit);

endmodule : rpcc_ctrl
`default_nettype wire

// *** verilog/rpcc_defs.svh ***
// constants for the radio power-up and calibration control block
`ifndef RPCC_DEFS_SVH
`define RPCC_DEFS_SVH

// register map
`define RPCC_TIMING_CFG_ADDR  6'h17
`define RPCC_TIMING_CFG_RESET 8'h04
`define RPCC_CFG_USED_MASK    8'h3F

// field positions inside the timing config register
`define RPCC_AUTOCAL_LSB      4
`define RPCC_EXPIRY_SEL_LSB   2
`define RPCC_KEEP_ON_BIT      0

// six-bit ripple counter and expiry counts per select value
`define RPCC_RIPPLE_MAX       6'h3F
`define RPCC_EXPIRY_SEL0      9'h001
`define RPCC_EXPIRY_SEL1      9'h010
`define RPCC_EXPIRY_SEL2      9'h040
`define RPCC_EXPIRY_SEL3      9'h100

// every-fourth return option: last count before calibrating
`define RPCC_RETURN_LAST      2'h3

`endif

// *** verilog/rpcc_pkg.sv ***
// types shared by the power-up and calibration control block
`default_nettype none
package rpcc_pkg;

  // when automatic synthesizer calibration happens
  typedef enum logic [1:0] {
    RPCC_CAL_NEVER     = 2'b00,
    RPCC_CAL_ON_START  = 2'b01,
    RPCC_CAL_ON_RETURN = 2'b10,
    RPCC_CAL_EVERY_4TH = 2'b11
  } rpcc_cal_mode_t;

  // layout of the timing config register
  typedef struct packed {
    logic [1:0]     unused;                // reads as zero
    rpcc_cal_mode_t synth_autocal_select;  // calibration policy
    logic [1:0]     powerup_expiry_select; // ripple expiries before ready
    logic           tuning_bit;            // plain storage bit
    logic           osc_keep_on_in_sleep;  // oscillator stays on in sleep
  } rpcc_cfg_t;

  // radio state events seen by the block
  typedef struct packed {
    logic idle_to_active;   // idle into rx, tx or synth-on-for-transmit
    logic auto_return_idle; // automatic return from rx or tx to idle
    logic synth_cal_strobe; // manual calibrate command
  } rpcc_evt_t;

endpackage : rpcc_pkg
`default_nettype wire

// *** verilog/rpcc_powerup_timer.sv ***
// ripple-counter timeout from oscillator settle to chip ready
`timescale 1ns/1ps
`default_nettype none
`include "rpcc_defs.svh"

module rpcc_powerup_timer
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // control
  input  wire logic       osc_settled,
  input  wire logic [1:0] expiry_select,
  // result
  output logic            timeout_done
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0] ripple;   // six-bit ripple counter
    logic [8:0] expiries; // expiries seen so far
    logic       done;     // timeout reached
  } rpcc_tmr_t;

  rpcc_tmr_t  st_ff;      // registered state
  rpcc_tmr_t  nxt_st;     // next state
  logic [8:0] target;     // expiries required

  // expiry count chosen by the select field
  always_comb
  begin
    unique case (expiry_select)
      2'h0:    target = `RPCC_EXPIRY_SEL0;
      2'h1:    target = `RPCC_EXPIRY_SEL1;
      2'h2:    target = `RPCC_EXPIRY_SEL2;
      default: target = `RPCC_EXPIRY_SEL3;
    endcase
  end

  // count ripple expiries while the oscillator is settled
  always_comb
  begin
    nxt_st = st_ff;
    if (!osc_settled)
    begin
      // oscillator gone: restart from scratch
      nxt_st = '0;
    end
    else if (!st_ff.done)
    begin
      nxt_st.ripple = st_ff.ripple + 6'h01;
      if (st_ff.ripple == `RPCC_RIPPLE_MAX)
      begin
        nxt_st.expiries = st_ff.expiries + 9'h001;
        if (st_ff.expiries + 9'h001 >= target)
          nxt_st.done = 1'b1;
      end
    end
  end

  // register state, frozen while clock enable is low
  always_ff @(posedge core_clk)
  begin
    if (reset)
      st_ff <= '0;
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign timeout_done = st_ff.done;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_timer_fires: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && osc_settled && !st_ff.done && st_ff.ripple == `RPCC_RIPPLE_MAX
    && st_ff.expiries + 9'h001 == target |=> st_ff.done)
    else $error("timer did not finish on last expiry");

  a_timer_early: assert property (@(posedge core_clk) disable iff (reset)
    $rose(st_ff.done) |-> $past(st_ff.ripple) == `RPCC_RIPPLE_MAX)
    else $error("timer finished off a ripple expiry");

endmodule : rpcc_powerup_timer
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking testbench for the power-up and calibration control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                 core_clk;    // 25 MHz clock
  logic                 reset;       // sync reset
  logic                 clk_en;      // clock enable
  logic                 cfg_wr_en;   // register write strobe
  logic [5:0]           cfg_addr;    // register address
  logic [7:0]           cfg_wdata;   // register write data
  logic [7:0]           cfg_rdata;   // register read data
  rpcc_pkg::rpcc_evt_t  radio_evt;   // radio state events
  logic                 osc_settled; // oscillator settled
  logic                 sleep_active; // radio asleep
  logic                 synth_cal_start;
  logic                 crystal_osc_enable;
  logic                 chip_ready_low;
  logic                 osc_stable_flag;
  int                   num_errors;  // mismatches seen
  int                   compares;    // comparisons made
  int                   cnt[4] = '{64, 1024, 4096, 16384}; // edges to done

  // design under test
  rpcc_ctrl dut_u
  (
    .core_clk           (core_clk),
    .reset              (reset),
    .clk_en             (clk_en),
    .cfg_wr_en          (cfg_wr_en),
    .cfg_addr           (cfg_addr),
    .cfg_wdata          (cfg_wdata),
    .cfg_rdata          (cfg_rdata),
    .radio_evt          (radio_evt),
    .osc_settled        (osc_settled),
    .sleep_active       (sleep_active),
    .synth_cal_start    (synth_cal_start),
    .crystal_osc_enable (crystal_osc_enable),
    .chip_ready_low     (chip_ready_low),
    .osc_stable_flag    (osc_stable_flag)
  );

  // ---------------------------------------------------------------
  // clock and helpers
  // ---------------------------------------------------------------
  // half period of 20 ns
  always #20 core_clk = ~core_clk;

  // compare seen against expected
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // hold reset for five cycles
  task do_reset;
    reset = 1'b1;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
  endtask : do_reset

  // one-cycle register write
  task wr(input logic [5:0] a, input logic [7:0] d);
    cfg_addr  = a;
    cfg_wdata = d;
    cfg_wr_en = 1'b1;
    @(negedge core_clk);
    cfg_wr_en = 1'b0;
  endtask : wr

  // register read, data one edge after the address
  task rd(input logic [5:0] a, input logic [7:0] x);
    cfg_addr = a;
    @(negedge core_clk);
    chk(cfg_rdata, x);
  endtask : rd

  // event pulse, calibration pulse expected one edge later
  task ev(input logic [2:0] e, input logic x);
    radio_evt = e;
    @(negedge core_clk);
    radio_evt = 3'h0;
    chk(8'(synth_cal_start), 8'(x));
    @(negedge core_clk);
    chk(8'(synth_cal_start), 8'h00);
  endtask : ev

  // verdict and end of run
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // watchdog well past the longest expected run
  initial
  begin
    #2000000;
    num_errors++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    core_clk     = 1'b0;
    clk_en       = 1'b1;
    cfg_wr_en    = 1'b0;
    cfg_addr     = 6'h00;
    cfg_wdata    = 8'h00;
    radio_evt    = 3'h0;
    osc_settled  = 1'b0;
    sleep_active = 1'b0;
    num_errors   = 0;
    compares     = 0;
    do_reset();
    // register reset values and access kinds
    rd(6'h17, 8'h04);
    rd(6'h16, 8'h00);
    chk(8'(chip_ready_low), 8'h01);
    chk(8'(osc_stable_flag), 8'h00);
    wr(6'h17, 8'hFF);
    rd(6'h17, 8'h3F);
    wr(6'h16, 8'h00);
    rd(6'h17, 8'h3F);
    do_reset();
    rd(6'h17, 8'h04);
    $display("test registers done");
    // calibration policy per select value
    for (int m = 0; m < 4; m++)
    begin
      wr(6'h17, {2'b00, 2'(m), 4'h8});
      ev(3'b001, 1'b1);
      ev(3'b100, m == 1);
      for (int i = 0; i < ((m == 3) ? 6 : 4); i++)
        ev(3'b010, (m == 2) || (m == 3 && i == 3));
    end
    // frozen clock enable ignores events
    clk_en = 1'b0;
    ev(3'b001, 1'b0);
    clk_en = 1'b1;
    // return counter restarts after reset
    do_reset();
    wr(6'h17, 8'h38);
    for (int i = 0; i < 4; i++)
      ev(3'b010, i == 3);
    $display("test calibration done");
    // power-up timeout for every expiry select
    for (int s = 0; s < 4; s++)
    begin
      osc_settled = 1'b0;
      wr(6'h17, {4'h0, 2'(s), 2'b00});
      repeat (2) @(negedge core_clk);
      chk(8'(chip_ready_low), 8'h01);
      osc_settled = 1'b1;
      repeat (cnt[s]) @(negedge core_clk);
      chk(8'(chip_ready_low), 8'h01);
      chk(8'(osc_stable_flag), 8'h00);
      @(negedge core_clk);
      chk(8'(chip_ready_low), 8'h00);
      chk(8'(osc_stable_flag), 8'h01);
    end
    osc_settled = 1'b0;
    $display("test power-up done");
    // oscillator in sleep with and without keep-on
    wr(6'h17, 8'h04);
    sleep_active = 1'b1;
    @(negedge core_clk);
    chk(8'(crystal_osc_enable), 8'h00);
    wr(6'h17, 8'h09);
    @(negedge core_clk);
    chk(8'(crystal_osc_enable), 8'h01);
    wr(6'h17, 8'h08);
    @(negedge core_clk);
    chk(8'(crystal_osc_enable), 8'h00);
    sleep_active = 1'b0;
    @(negedge core_clk);
    chk(8'(crystal_osc_enable), 8'h01);
    $display("test oscillator done");
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
